/* rtl/dswp_pkg.sv */
package dswp_pkg;
    localparam int unsigned WORD_W      = 16;
    localparam int unsigned FIFO_DEPTH  = 8;
    localparam int unsigned CNT_W       = 6;
    localparam logic [5:0]  EDGE_COMMIT = 6'h10;
    localparam logic [5:0]  EDGE_MAX    = 6'h3F;
    localparam logic [15:0] WORD_RST    = 16'h0000;
    localparam logic [3:0]  CHAN_RST    = 4'h0;
endpackage

/* rtl/dswp_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module dswp_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic      [WIDTH-1:0] out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW:0]                 wp;
        logic [AW:0]                 rp;
    } dswp_fifo_s;
    dswp_fifo_s st_ff;
    dswp_fifo_s nxt_st;
    logic       push;
    logic       pop;
    assign in_ready  = (st_ff.wp - st_ff.rp) != (AW+1)'(DEPTH);
    assign out_valid = st_ff.wp != st_ff.rp;
    assign out_data  = st_ff.mem[st_ff.rp[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    always_comb begin
        nxt_st = st_ff;
        if (push) begin
            nxt_st.mem[st_ff.wp[AW-1:0]] = in_data;
            nxt_st.wp                    = st_ff.wp + 1'b1;
        end
        if (pop) begin
            nxt_st.rp = st_ff.rp + 1'b1;
        end
        if (!rst_n) begin
            nxt_st = '0;
        end
    end
    always_ff @(posedge clk) begin
        st_ff <= nxt_st;
    end
endmodule // dswp_fifo
`default_nettype wire

/* rtl/dswp_top.sv */
// Overview of operation
// RULE_01: Shift data in on serial clock falls.
// RULE_02: Strobe rise after sixteen edges commits word. The code drops the word instead when the FIFO is full (f_ready low).
// RULE_03: Early strobe rise discards partial word.
// RULE_04: Output valid only past sixteen clocks.
// RULE_05: Output chains to next device input.
// RULE_06: Host lowers strobe, data sampled falling.
// RULE_07: Committed word drives mode and channels.
// RULE_08: Outputs zero until first valid commit.
// RULE_09: Fifteen edges only is also aborted.
`timescale 1ns/1ps
`default_nettype none
module dswp_top (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        frame_n,
    input  wire logic        sclk,
    input  wire logic        sdin,
    output logic             sdout,
    output logic             sdout_valid,
    output logic [15:0]      word_out,
    output logic             word_valid,
    input  wire logic        word_ready,
    output logic [3:0]       mode_out,
    output logic [11:0]      value_out,
    output logic             loaded
);

    typedef struct packed {
        logic        sclk_d;
        logic        frame_d;
        logic [15:0] shreg;
        logic [5:0]  edges;
        logic        sdout;
        logic        sdout_valid;
        logic [15:0] commit;
        logic        push;
        logic [15:0] word;
        logic        wvalid;
        logic [3:0]  mode;
        logic [11:0] value;
        logic        loaded;
    } dswp_state_s;

    dswp_state_s st_ff;
    dswp_state_s nxt_st;
    logic [15:0] f_data;
    logic        f_valid;
    logic        f_ready;
    logic        f_pop;
    logic        fall;
    logic        rise;

    assign fall  = st_ff.sclk_d && !sclk;
    assign rise  = !st_ff.frame_d && frame_n;
    assign f_pop = f_valid && (!st_ff.wvalid || word_ready);

    dswp_fifo #(.WIDTH(dswp_pkg::WORD_W), .DEPTH(dswp_pkg::FIFO_DEPTH)) dswp_fifo_i (
        .clk       (clk),
        .rst_n     (rst_n),
        .in_data   (st_ff.commit),
        .in_valid  (st_ff.push),
        .in_ready  (f_ready),
        .out_data  (f_data),
        .out_valid (f_valid),
        .out_ready (f_pop)
    );

    // RULE_02: sixteen falls make a frame.
    function automatic logic full_frame(input logic [5:0] count);
        return count >= dswp_pkg::EDGE_COMMIT;
    endfunction

    always_comb begin
        nxt_st         = st_ff;
        nxt_st.sclk_d  = sclk;
        nxt_st.frame_d = frame_n;
        nxt_st.push    = 1'b0;
        if (!frame_n && fall) begin
            // RULE_01: shift on fall.
            nxt_st.shreg = {st_ff.shreg[14:0], sdin};
            if (st_ff.edges != dswp_pkg::EDGE_MAX) begin
                nxt_st.edges = st_ff.edges + 6'h01;
            end
            // RULE_04: chained output past sixteen.
            // RULE_05: chained output bit.
            nxt_st.sdout       = st_ff.shreg[15];
            nxt_st.sdout_valid = full_frame(st_ff.edges);
        end
        if (rise) begin
            // RULE_02: commit on rise.
            // RULE_03: discard short frame.
            // RULE_09: fifteen edges aborted.
            if (full_frame(st_ff.edges) && f_ready) begin
                nxt_st.commit = st_ff.shreg;
                nxt_st.push   = 1'b1;
            end
            nxt_st.edges       = '0;
            nxt_st.sdout_valid = 1'b0;
        end
        if (f_pop) begin
            nxt_st.word   = f_data;
            nxt_st.wvalid = 1'b1;
            // RULE_07: word selects mode and value.
            nxt_st.mode   = f_data[15:12];
            nxt_st.value  = f_data[11:0];
            // RULE_08: loaded after first commit.
            nxt_st.loaded = 1'b1;
        end else if (word_ready) begin
            nxt_st.wvalid = 1'b0;
        end
        if (!rst_n) begin
            nxt_st        = '0;
            nxt_st.sclk_d  = sclk;
            nxt_st.frame_d = frame_n;
            nxt_st.word   = dswp_pkg::WORD_RST;
            nxt_st.mode   = dswp_pkg::CHAN_RST;
        end
    end

    always_ff @(posedge clk) begin
        st_ff <= nxt_st;
    end

    assign sdout       = st_ff.sdout;
    assign sdout_valid = st_ff.sdout_valid;
    assign word_out    = st_ff.word;
    assign word_valid  = st_ff.wvalid;
    assign mode_out    = st_ff.mode;
    assign value_out   = st_ff.value;
    assign loaded      = st_ff.loaded;

    // RULE_03: no push without sixteen edges.
    chk_short_abort: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
        (rise && st_ff.edges < 6'h10) |=> !st_ff.push)
        else $error("short frame pushed");
    // RULE_02: full frame pushes next cycle.
    chk_full_commit: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
        (rise && st_ff.edges >= 6'h10 && f_ready) |=> (st_ff.push && st_ff.commit == $past(st_ff.shreg)))
        else $error("full frame not committed");
    // RULE_04: chain output gated.
    chk_sdout_gate: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
        st_ff.sdout_valid |-> $past(st_ff.edges) >= 6'h10 || $past(st_ff.sdout_valid))
        else $error("chain output early");
    // RULE_01: shifting on fall.
    chk_shift_fall: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
        (!frame_n && fall && !rise) |=> st_ff.shreg[0] == $past(sdin))
        else $error("bit not shifted");
    // RULE_08: zero until loaded.
    chk_zero_load: assert property (@(posedge clk) disable iff (!rst_n) // RULE_08
        !st_ff.loaded |-> (st_ff.value == 12'h000 && st_ff.mode == 4'h0))
        else $error("output before load");
    // RULE_07: outputs follow word.
    chk_word_map: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
        st_ff.loaded |-> {st_ff.mode, st_ff.value} == st_ff.word)
        else $error("outputs mismatch word");
    // RULE_09: fifteen edges aborts.
    chk_fifteen_abort: assert property (@(posedge clk) disable iff (!rst_n) // RULE_09
        (rise && st_ff.edges == 6'h0F) |=> !st_ff.push)
        else $error("fifteen edge frame pushed");
    // RULE_04: rise clears chain valid.
    chk_rise_clear: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
        rise |=> !st_ff.sdout_valid)
        else $error("chain valid kept");
    // RULE_08: reset clears outputs.
    chk_reset_clear: assert property (@(posedge clk) // RULE_08
        !rst_n |=> (!st_ff.loaded && !st_ff.wvalid && !st_ff.sdout_valid && !st_ff.push))
        else $error("reset left outputs set");
    // RULE_01: falls are counted.
    chk_edge_count: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
        (!frame_n && fall && st_ff.edges != dswp_pkg::EDGE_MAX) |=> st_ff.edges == $past(st_ff.edges) + 6'h01)
        else $error("fall not counted");
    // RULE_03: rise restarts count.
    chk_rise_edges: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
        rise |=> st_ff.edges == 6'h00)
        else $error("count kept after rise");
    // RULE_02: push only after rise.
    chk_push_source: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
        st_ff.push |-> $past(rise))
        else $error("push without rise");
    // RULE_09: push needs sixteen falls.
    chk_push_count: assert property (@(posedge clk) disable iff (!rst_n) // RULE_09
        st_ff.push |-> full_frame($past(st_ff.edges)))
        else $error("push on short frame");
    // RULE_05: chained bit shifted out.
    chk_chain_bit: assert property (@(posedge clk) disable iff (!rst_n) // RULE_05
        (!frame_n && fall) |=> st_ff.sdout == $past(st_ff.shreg[15]))
        else $error("chain bit wrong");
    // RULE_04: chain valid held.
    chk_chain_keep: assert property (@(posedge clk) disable iff (!rst_n) // RULE_04
        (st_ff.sdout_valid && !rise) |=> st_ff.sdout_valid)
        else $error("chain valid dropped");
    // RULE_01: no shift while idle.
    chk_idle_hold: assert property (@(posedge clk) disable iff (!rst_n) // RULE_01
        frame_n |=> st_ff.shreg == $past(st_ff.shreg))
        else $error("shift outside frame");
    // RULE_03: abort keeps last commit.
    chk_abort_keep: assert property (@(posedge clk) disable iff (!rst_n) // RULE_03
        (rise && !full_frame(st_ff.edges)) |=> st_ff.commit == $past(st_ff.commit))
        else $error("abort changed commit");
    // RULE_02: full buffer drops frame.
    chk_full_drop: assert property (@(posedge clk) disable iff (!rst_n) // RULE_02
        (rise && full_frame(st_ff.edges) && !f_ready) |=> !st_ff.push)
        else $error("push into full buffer");
    // RULE_07: popped word shown.
    chk_pop_word: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
        f_pop |=> (st_ff.wvalid && st_ff.word == $past(f_data)))
        else $error("popped word lost");
    // RULE_07: word held until taken.
    chk_word_hold: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
        (st_ff.wvalid && !word_ready) |=> (st_ff.wvalid && st_ff.word == $past(st_ff.word)))
        else $error("word not held");
    // RULE_07: taken word released.
    chk_valid_drop: assert property (@(posedge clk) disable iff (!rst_n) // RULE_07
        (st_ff.wvalid && word_ready && !f_valid) |=> !st_ff.wvalid)
        else $error("word valid stuck");
    // RULE_08: loaded stays set.
    chk_load_keep: assert property (@(posedge clk) disable iff (!rst_n) // RULE_08
        st_ff.loaded |=> st_ff.loaded)
        else $error("loaded flag dropped");

    cov_commit: cover property (@(posedge clk) st_ff.push);
    cov_chain: cover property (@(posedge clk) st_ff.sdout_valid);
    cov_full: cover property (@(posedge clk) !f_ready);
    cov_abort: cover property (@(posedge clk) rise && !full_frame(st_ff.edges));
    cov_drop: cover property (@(posedge clk) rise && full_frame(st_ff.edges) && !f_ready);
endmodule // dswp_top
`default_nettype wire

/* test/dswp_host.sv */
`timescale 1ns/1ps
`default_nettype none
module dswp_host (
    input  wire logic clk,
    output logic      frame_n,
    output logic      sclk,
    output logic      sdin
);
    initial begin
        frame_n = 1'b1;
        sclk    = 1'b0;
        sdin    = 1'b0;
    end
    task automatic shift(input logic [19:0] data, input int n);
        @(negedge clk) frame_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            sdin = data[i];
            @(negedge clk) sclk = 1'b1;
            @(negedge clk);
            @(negedge clk) sclk = 1'b0;
            @(negedge clk);
        end
    endtask
    // Released data shows the inverse of the last bit.
    task automatic end_frame();
        frame_n = 1'b1;
        sdin    = ~sdin;
        @(negedge clk);
    endtask
endmodule // dswp_host
`default_nettype wire

/* test/dswp_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module dswp_top_bench;
    logic        clk, rst_n, frame_n, sclk, sdin, sdout, sdout_valid;
    logic        word_valid, word_ready, loaded;
    logic [15:0] word_out;
    logic [3:0]  mode_out;
    logic [11:0] value_out;
    int          num_errors = 0;
    int          n_compared = 0;
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    dswp_host dswp_host_i (.clk(clk), .frame_n(frame_n), .sclk(sclk), .sdin(sdin));
    dswp_top dswp_top_i (.clk(clk), .rst_n(rst_n), .frame_n(frame_n), .sclk(sclk), .sdin(sdin),
        .sdout(sdout), .sdout_valid(sdout_valid), .word_out(word_out), .word_valid(word_valid),
        .word_ready(word_ready), .mode_out(mode_out), .value_out(value_out), .loaded(loaded));
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic expect_word(input logic [15:0] exp);
        int k;
        k = 0;
        while (word_valid !== 1'b1 && k < 20) begin
            @(negedge clk);
            k++;
        end
        check("word_valid", 16'h1, {15'h0, word_valid});
        check("word_out", exp, word_out);
    endtask
    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic test_full();
        dswp_host_i.shift(20'h0A5C3, 16);
        check("sdout_valid", 16'h0, {15'h0, sdout_valid});
        dswp_host_i.end_frame();
        expect_word(16'hA5C3);
        repeat (3) @(negedge clk);
        check("mode_out", 16'h000A, {12'h0, mode_out});
        check("value_out", 16'h05C3, {4'h0, value_out});
        check("loaded", 16'h1, {15'h0, loaded});
        $display("test full frame done");
    endtask
    task automatic test_abort(input int n);
        int seen;
        seen = 0;
        dswp_host_i.shift(20'h0FFFF, n);
        dswp_host_i.end_frame();
        repeat (10) @(negedge clk) if (word_valid === 1'b1) seen++;
        check("abort_commit", 16'h0, seen[15:0]);
        check("abort_mode", 16'h000A, {12'h0, mode_out});
        $display("test abort %0d done", n);
    endtask
    task automatic test_chain(input logic [19:0] data);
        dswp_host_i.shift(data, 20);
        check("sdout_valid", 16'h1, {15'h0, sdout_valid});
        check("sdout", {15'h0, data[16]}, {15'h0, sdout});
        dswp_host_i.end_frame();
        expect_word(data[15:0]);
        $display("test chain done");
    endtask
    task automatic test_fifo();
        repeat (2) @(negedge clk);
        word_ready = 1'b0;
        for (int i = 0; i < 10; i++) begin
            dswp_host_i.shift({4'h0, 16'h3C00 + 16'(i)}, 16);
            dswp_host_i.end_frame();
        end
        for (int i = 0; i < 9; i++) begin
            expect_word(16'h3C00 + 16'(i));
            word_ready = 1'b1;
            @(negedge clk) word_ready = 1'b0;
            repeat (2) @(negedge clk);
        end
        check("fifo_drop", 16'h0, {15'h0, word_valid});
        word_ready = 1'b1;
        $display("test fifo done");
    endtask
    task automatic test_reset(input int cycles);
        rst_n = 1'b0;
        repeat (cycles) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        check("reset_loaded", 16'h0, {15'h0, loaded});
        check("reset_value", 16'h0, {4'h0, value_out});
        check("reset_mode", 16'h0, {12'h0, mode_out});
        check("reset_valid", 16'h0, {14'h0, word_valid, sdout_valid});
        $display("test reset done");
    endtask
    initial begin
        word_ready = 1'b1;
        test_reset(6);
        test_full();
        test_abort(14);
        test_abort(15);
        test_chain(20'hA1234);
        test_chain(20'h51234);
        test_fifo();
        test_reset(2);
        test_full();
        complete_run();
    end
    initial begin
        repeat (6000) @(posedge clk);
        num_errors++;
        $display("watchdog expired");
        complete_run();
    end
endmodule // dswp_top_bench
`default_nettype wire
